/* File: verilog/bbsc_top.sv */
`timescale 1ns/1ps
`include "bbsc_regs.svh"
// Summary of operation
// [RULE1] blank low forces zeroes onto DACs
// [RULE2] active pixels routed, cursor overrides pixel
// [RULE3] blanking counts 2048 pixels, flags frame end
// [RULE4] frame end feeds cursor and signature logic; here frame_end only drives frame_end_out
// [RULE5] controller keeps border low during blank
// [RULE6] border low outside blank shows border colour
// [RULE7] cursor area needs blank and border high
// [RULE8] signature accumulates whenever blank is high
// [RULE9] border changes only whole lines or edges
// [RULE10] bypass bit passes line sync straight through
// [RULE11] otherwise line sync latched, pipeline delayed
// [RULE12] sync on green forces line sync passthrough
// [RULE13] frame sync passes unlatched, no delay
// [RULE14] combined sync latched, delayed onto green
// [RULE15] position adds 0 to 15 pixel delays
// [RULE16] position applies to the active delayed path
// [RULE17] combined sync invert before green injection
// [RULE18] line and frame sync invert bits
// [RULE19] drive fields force low, high or hiz
// [RULE20] sync clock gate stops delay circuits
// [RULE21] partition supplies upper index bits
// [RULE22] low bit fill per fill select
// [RULE23] sync delay equals pixel pipeline latency
module bbsc_top (
    input wire logic clk_in,
    input wire logic arst_n_in,
    // load clock and video controls from the controller
    input wire logic load_clock_in,
    input wire logic blank_n_in,
    input wire logic border_n_in,
    input wire logic line_sync_in,
    input wire logic frame_or_combined_sync_in,
    // pixel stream, already formatted as 24-bit colour
    input wire logic [23:0] pixel_in,
    input wire logic [23:0] border_colour_in,
    input wire logic cursor_show_in,
    input wire logic [23:0] cursor_colour_in,
    // pixel format inputs
    input wire logic [1:0] bits_per_pixel_in,
    input wire logic contig_format_in,
    input wire logic [3:0] palette_partition_in,
    input wire logic low_bit_fill_sel_in,
    // register port
    input wire logic [7:0] reg_index_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    output logic [7:0] reg_rdata_out,
    // DAC side
    output logic [23:0] dac_data_out,
    output logic dac_sync_on_green_out,
    output logic [7:0] palette_index_hi_out,
    output logic [7:0] fill_bits_out,
    output logic line_sync_out,
    output logic line_sync_oe_out,
    output logic frame_sync_out,
    output logic frame_sync_oe_out,
    output logic frame_end_out,
    output logic cursor_area_out,
    output logic signature_en_out,
    output logic data_stall_out
);
    import bbsc_pkg::*;

    logic [1:0] rst_sync;
    logic rst_n;
    logic [2:0] load_clock_sync;
    logic pix_en;
    logic [1:0] blank_sync;
    logic [1:0] border_sync;
    logic [1:0] hs_sync;
    logic [1:0] vcs_sync;
    logic blank_n;
    logic border_n;
    logic hs_latched;
    logic cs_latched;
    logic [11:0] blank_count;
    logic frame_end;
    logic [7:0] sync_control;
    logic [7:0] hsync_position;
    logic [7:0] power_management;
    logic [7:0] dac_operation;
    logic [`BBSC_PIPE_LATENCY+`BBSC_MAX_POSITION:0] hs_pipe;
    logic [`BBSC_PIPE_LATENCY+`BBSC_MAX_POSITION:0] cs_pipe;
    logic sync_on_green_en;
    logic bypass;
    logic gate;
    logic [3:0] position;
    logic hs_delayed;
    logic cs_delayed;
    logic hs_sel;
    logic vs_sel;
    bbsc_src_t src;
    logic [23:0] next_dac;
    logic fifo_wr_ready;
    logic [23:0] fifo_data;
    logic fifo_valid;

    // reset release through two flops
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // pins are asynchronous to clk_in, two flops each, three for the load clock
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            load_clock_sync <= 3'h0;
            blank_sync <= 2'h0;
            border_sync <= 2'h0;
            hs_sync <= 2'h0;
            vcs_sync <= 2'h0;
        end else begin
            load_clock_sync <= {load_clock_sync[1:0], load_clock_in};
            blank_sync <= {blank_sync[0], blank_n_in};
            border_sync <= {border_sync[0], border_n_in};
            hs_sync <= {hs_sync[0], line_sync_in};
            vcs_sync <= {vcs_sync[0], frame_or_combined_sync_in};
        end
    end
    // rising load clock edge seen on synchronised copies only
    assign pix_en = load_clock_sync[1] && !load_clock_sync[2];

    // controls latched on the load clock rising edge
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            blank_n <= 1'b0;
            border_n <= 1'b0;
            hs_latched <= 1'b0;
            cs_latched <= 1'b0;
        end else if (pix_en) begin
            blank_n <= blank_sync[1]; // RULE1
            border_n <= border_sync[1]; // RULE5
            hs_latched <= hs_sync[1]; // RULE11
            cs_latched <= vcs_sync[1]; // RULE14
        end
    end

    // registers; unknown indices are ignored on write, read as zero
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            sync_control <= `BBSC_RST_SYNC_CONTROL;
            hsync_position <= `BBSC_RST_HSYNC_POSITION;
            power_management <= `BBSC_RST_POWER_MANAGEMENT;
            dac_operation <= `BBSC_RST_DAC_OPERATION;
        end else if (reg_write_in) begin
            case (reg_index_in)
                `BBSC_IDX_SYNC_CONTROL: sync_control <= reg_wdata_in;
                `BBSC_IDX_HSYNC_POSITION: hsync_position <= reg_wdata_in;
                `BBSC_IDX_POWER_MANAGEMENT: power_management <= reg_wdata_in;
                `BBSC_IDX_DAC_OPERATION: dac_operation <= reg_wdata_in;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_out <= 8'h00;
        end else begin
            case (reg_index_in)
                `BBSC_IDX_SYNC_CONTROL: reg_rdata_out <= sync_control;
                `BBSC_IDX_HSYNC_POSITION: reg_rdata_out <= hsync_position;
                `BBSC_IDX_POWER_MANAGEMENT: reg_rdata_out <= power_management;
                `BBSC_IDX_DAC_OPERATION: reg_rdata_out <= dac_operation;
                default: reg_rdata_out <= 8'h00;
            endcase
        end
    end

    assign sync_on_green_en = dac_operation[`BBSC_DO_SYNC_ON_GREEN];
    assign bypass = sync_control[`BBSC_SC_DELAY_BYPASS];
    assign gate = power_management[`BBSC_PM_SYNC_CLOCK_GATE];
    assign position = hsync_position[3:0]; // RULE15

    // blanking pixel counter saturates, flag held until blank lifts
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            blank_count <= 12'h000;
            frame_end <= 1'b0;
        end else if (pix_en) begin
            if (blank_sync[1]) begin
                blank_count <= 12'h000;
                frame_end <= 1'b0;
            end else if (blank_count >= `BBSC_FRAME_END_COUNT) begin
                frame_end <= 1'b1; // RULE3
            end else begin
                blank_count <= blank_count + 12'h001;
            end
        end
    end

    // sync delay lines; gating freezes them to save power
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            hs_pipe <= '0;
            cs_pipe <= '0;
        end else if (pix_en && !gate) begin // RULE20
            hs_pipe <= {hs_pipe[$high(hs_pipe)-1:0], hs_latched}; // RULE23
            cs_pipe <= {cs_pipe[$high(cs_pipe)-1:0], cs_latched};
        end
    end
    // tap = fixed latency plus position
    assign hs_delayed = hs_pipe[`BBSC_PIPE_LATENCY - 1 + position]; // RULE16
    assign cs_delayed = cs_pipe[`BBSC_PIPE_LATENCY - 1 + position]; // RULE16

    // line sync: direct pin on bypass or sync on green, else delayed
    always_comb begin
        if (bypass || sync_on_green_en) begin
            hs_sel = hs_sync[1]; // RULE10 RULE12
        end else begin
            hs_sel = hs_delayed; // RULE11
        end
        hs_sel = hs_sel ^ sync_control[`BBSC_SC_LINE_INVERT]; // RULE18
        vs_sel = vcs_sync[1] ^ sync_control[`BBSC_SC_FRAME_INVERT]; // RULE13 RULE18
    end

    // drive selection per output
    function automatic logic [1:0] drive(input logic [1:0] sel, input logic level);
        bbsc_drive_t d;
        d = bbsc_drive_t'(sel);
        unique case (d)
            BBSC_DRV_NORMAL: drive = {level, 1'b1};
            BBSC_DRV_LOW: drive = 2'b01;
            BBSC_DRV_HIGH: drive = 2'b11;
            BBSC_DRV_HIZ: drive = 2'b00;
        endcase
    endfunction

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            line_sync_out <= 1'b0;
            line_sync_oe_out <= 1'b0;
            frame_sync_out <= 1'b0;
            frame_sync_oe_out <= 1'b0;
            dac_sync_on_green_out <= 1'b0;
        end else begin
            {line_sync_out, line_sync_oe_out} <= drive(sync_control[1:0], hs_sel); // RULE19
            {frame_sync_out, frame_sync_oe_out} <= drive(sync_control[3:2], vs_sel); // RULE19
            dac_sync_on_green_out <= sync_on_green_en && (cs_delayed ^ sync_control[`BBSC_SC_COMBINED_INVERT]); // RULE14 RULE17
        end
    end

    // source select: blank wins, then border, then cursor over pixel
    always_comb begin
        if (!blank_n) begin
            src = BBSC_SRC_ZERO; // RULE1
        end else if (!border_n) begin
            src = BBSC_SRC_BORDER; // RULE6
        end else if (cursor_show_in) begin
            src = BBSC_SRC_CURSOR; // RULE2
        end else begin
            src = BBSC_SRC_PIXEL; // RULE2
        end
        unique case (src)
            BBSC_SRC_ZERO: next_dac = 24'h000000;
            BBSC_SRC_BORDER: next_dac = border_colour_in;
            BBSC_SRC_CURSOR: next_dac = cursor_colour_in;
            BBSC_SRC_PIXEL: next_dac = fifo_valid ? fifo_data : 24'h000000;
        endcase
    end

    // pixel buffer; only active pixels go in, so border lines cannot overfill it
    bbsc_fifo #(.WIDTH(24), .DEPTH(8)) u_fifo (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .wr_data_in(pixel_in),
        .wr_valid_in(pix_en && blank_sync[1] && border_sync[1]), // RULE2
        .wr_ready_out(fifo_wr_ready),
        .rd_data_out(fifo_data),
        .rd_valid_out(fifo_valid),
        .rd_ready_in(pix_en && blank_n && border_n)
    );

    // DAC data and status flags
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            dac_data_out <= 24'h000000;
            frame_end_out <= 1'b0;
            cursor_area_out <= 1'b0;
            signature_en_out <= 1'b0;
            data_stall_out <= 1'b0;
            palette_index_hi_out <= 8'h00;
            fill_bits_out <= 8'h00;
        end else begin
            if (pix_en) begin
                dac_data_out <= next_dac;
            end
            frame_end_out <= frame_end; // RULE4
            cursor_area_out <= blank_n && border_n; // RULE7
            signature_en_out <= blank_n; // RULE8
            data_stall_out <= !fifo_wr_ready;
            // 4 bpp or contiguous 15/16 take partition as upper bits
            if (bits_per_pixel_in == 2'b00 || (bits_per_pixel_in == 2'b10 && contig_format_in)) begin
                palette_index_hi_out <= {palette_partition_in, 4'h0}; // RULE21
            end else begin
                palette_index_hi_out <= 8'h00;
            end
            // fill low bits: linear replicates ones outside contiguous format, zero fill gives zeros
            fill_bits_out <= (low_bit_fill_sel_in && !contig_format_in) ? 8'hFF : 8'h00; // RULE22
        end
    end
endmodule

/* File: verilog/bbsc_regs.svh */
`ifndef BBSC_REGS_SVH
`define BBSC_REGS_SVH
// register indices
`define BBSC_IDX_SYNC_CONTROL 8'h03
`define BBSC_IDX_HSYNC_POSITION 8'h04
`define BBSC_IDX_POWER_MANAGEMENT 8'h05
`define BBSC_IDX_DAC_OPERATION 8'h06
// sync_control fields
`define BBSC_SC_DELAY_BYPASS 7
`define BBSC_SC_COMBINED_INVERT 6
`define BBSC_SC_FRAME_INVERT 5
`define BBSC_SC_LINE_INVERT 4
`define BBSC_SC_FRAME_DRIVE_HI 3
`define BBSC_SC_FRAME_DRIVE_LO 2
`define BBSC_SC_LINE_DRIVE_HI 1
`define BBSC_SC_LINE_DRIVE_LO 0
// power_management and dac_operation fields
`define BBSC_PM_SYNC_CLOCK_GATE 5
`define BBSC_DO_SYNC_ON_GREEN 3
// reset values
`define BBSC_RST_SYNC_CONTROL 8'h00
`define BBSC_RST_HSYNC_POSITION 8'h00
`define BBSC_RST_POWER_MANAGEMENT 8'h00
`define BBSC_RST_DAC_OPERATION 8'h00
// timing counts in pixel (load clock) periods
`define BBSC_FRAME_END_COUNT 12'h7FF
`define BBSC_PIPE_LATENCY 4
`define BBSC_MAX_POSITION 15
`endif

/* File: verilog/bbsc_pkg.sv */
package bbsc_pkg;
    // source routed to the DACs
    typedef enum logic [1:0] {
        BBSC_SRC_ZERO = 2'b00,
        BBSC_SRC_BORDER = 2'b01,
        BBSC_SRC_PIXEL = 2'b11,
        BBSC_SRC_CURSOR = 2'b10
    } bbsc_src_t;
    // drive selection for a sync output
    typedef enum logic [1:0] {
        BBSC_DRV_NORMAL = 2'b00,
        BBSC_DRV_LOW = 2'b01,
        BBSC_DRV_HIGH = 2'b10,
        BBSC_DRV_HIZ = 2'b11
    } bbsc_drive_t;
endpackage

/* File: verilog/bbsc_fifo.sv */
`timescale 1ns/1ps
module bbsc_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    output logic [WIDTH-1:0] rd_data_out,
    output logic rd_valid_out,
    input wire logic rd_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic do_wr;
    logic do_rd;

    assign wr_ready_out = (count != (AW+1)'(DEPTH));
    assign rd_valid_out = (count != '0);
    assign rd_data_out = mem[rd_ptr];
    assign do_wr = wr_valid_in && wr_ready_out;
    assign do_rd = rd_valid_out && rd_ready_in;

    // storage has no reset; only the pointers matter
    always_ff @(posedge clk_in) begin
        if (do_wr) begin
            mem[wr_ptr] <= wr_data_in;
        end
    end

    // pointers wrap, depth is a power of two
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + AW'(1);
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + AW'(1);
            end
            if (do_wr && !do_rd) begin
                count <= count + (AW+1)'(1);
            end else if (do_rd && !do_wr) begin
                count <= count - (AW+1)'(1);
            end
        end
    end
endmodule

/* File: verif/bbsc_top_asserts.sv */
`timescale 1ns/1ps
module bbsc_top_asserts #(
    parameter int LDIV = 20
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic blank_n_in,
    input wire logic line_sync_in,
    input wire logic frame_or_combined_sync_in,
    input wire logic [7:0] reg_index_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic [23:0] dac_data_out,
    input wire logic line_sync_out,
    input wire logic line_sync_oe_out,
    input wire logic frame_sync_out,
    input wire logic frame_sync_oe_out,
    input wire logic frame_end_out,
    input wire logic cursor_area_out,
    input wire logic signature_en_out
);
    logic [7:0] sc;
    logic sync_on_green_en;
    logic [16:0] low_cnt;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    // shadow of the sync settings, follows the write port
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sc <= 8'h00;
            sync_on_green_en <= 1'b0;
        end else if (reg_write_in) begin
            if (reg_index_in == 8'h03) sc <= reg_wdata_in;
            if (reg_index_in == 8'h06) sync_on_green_en <= reg_wdata_in[3];
        end
    end
    // clk cycles with blank held low, saturates
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) low_cnt <= '0;
        else if (blank_n_in) low_cnt <= '0;
        else if (!low_cnt[16]) low_cnt <= low_cnt + 17'h00001;
    end
    sequence s_wr3;
        reg_write_in && reg_index_in == 8'h03;
    endsequence
    sequence s_rd3;
        !reg_write_in && reg_index_in == 8'h03;
    endsequence
    a_reg_read_back: assert property (s_wr3 ##1 s_rd3 |=> reg_rdata_out == $past(reg_wdata_in, 2))
        else $error("sync control read back differs");
    a_unmapped_read_zero: assert property (reg_index_in > 8'h06 |=> reg_rdata_out == 8'h00)
        else $error("unmapped index read not zero");
    a_frame_end_late: assert property ($rose(frame_end_out) |-> low_cnt >= 2047 * LDIV)
        else $error("frame end flagged too early");
    a_frame_blank_zero: assert property (frame_end_out |-> dac_data_out == 24'h000000)
        else $error("dac not zero in frame blank");
    a_frame_no_sig: assert property (frame_end_out |-> !signature_en_out && !cursor_area_out)
        else $error("signature or cursor area during frame end");
    a_cursor_in_sig: assert property (cursor_area_out |-> signature_en_out)
        else $error("cursor area outside signature area");
    a_line_hiz_off: assert property ((sc[1:0] == 2'b11) [*3] |-> !line_sync_oe_out)
        else $error("line sync driven while high impedance");
    a_frame_force_hi: assert property ((sc[3:2] == 2'b10) [*5] |-> frame_sync_oe_out && frame_sync_out)
        else $error("frame sync not forced high");
    a_frame_follow: assert property ((sc[3:2] == 2'b00 && $stable(frame_or_combined_sync_in) && $stable(sc[5])) [*5]
        |-> frame_sync_oe_out && frame_sync_out == (frame_or_combined_sync_in ^ sc[5]))
        else $error("frame sync does not follow input");
    a_line_pass: assert property (((sc[7] || sync_on_green_en) && sc[1:0] == 2'b00 && $stable(line_sync_in) && $stable(sc[4])) [*5]
        |-> line_sync_out == (line_sync_in ^ sc[4]))
        else $error("line sync does not pass through");
endmodule
bind bbsc_top bbsc_top_asserts u_chk (.clk_in, .arst_n_in, .blank_n_in, .line_sync_in, .frame_or_combined_sync_in,
    .reg_index_in, .reg_wdata_in, .reg_write_in, .reg_rdata_out, .dac_data_out, .line_sync_out, .line_sync_oe_out,
    .frame_sync_out, .frame_sync_oe_out, .frame_end_out, .cursor_area_out, .signature_en_out);

/* File: verif/bbsc_ctrl_model.sv */
`timescale 1ns/1ps
module bbsc_ctrl_model (
    input wire logic run_in,
    input wire logic vblank_in,
    output logic load_clock_out,
    output logic blank_n_out = 1'b0,
    output logic border_n_out = 1'b0,
    output logic [23:0] pixel_out = 24'h000000
);
    logic [5:0] col = 6'h00;
    // load clock idles low until the controller runs
    initial begin
        load_clock_out = 1'b0;
        forever begin
            #80;
            load_clock_out = run_in & ~load_clock_out;
        end
    end
    // 64-pixel line: 8 blank, 4 border, 48 active, 4 border
    always @(posedge load_clock_out) begin
        col <= col + 6'h01;
        blank_n_out <= !vblank_in && col >= 6'h08;
        border_n_out <= !vblank_in && col >= 6'h0C && col < 6'h3C;
        // data is meaningless in blank, so keep it moving
        pixel_out <= (!vblank_in && col >= 6'h08) ? {3{2'b00, col}} : ~pixel_out;
    end
endmodule

/* File: verif/bbsc_top_tb.sv */
`timescale 1ns/1ps
module bbsc_top_tb;
    logic clk_in = 1'b0, arst_n_in = 1'b0, load_clock_in, blank_n_in, border_n_in, run = 1'b0, vblank = 1'b1;
    logic line_sync_in = 1'b0, frame_or_combined_sync_in = 1'b0, cursor_show_in = 1'b0, reg_write_in = 1'b0;
    logic [23:0] pixel_in, dac_data_out, border_colour_in = 24'h5A3C01, cursor_colour_in = 24'hC3E711;
    logic [1:0] bits_per_pixel_in = 2'h1;
    logic contig_format_in = 1'b0, low_bit_fill_sel_in = 1'b0;
    logic [3:0] palette_partition_in = 4'hA;
    logic [7:0] reg_index_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out, palette_index_hi_out, fill_bits_out;
    logic dac_sync_on_green_out, line_sync_out, line_sync_oe_out, frame_sync_out, frame_sync_oe_out;
    logic frame_end_out, cursor_area_out, signature_en_out, data_stall_out;
    logic [7:0] scv [6] = '{8'h80, 8'h90, 8'hA0, 8'h85, 8'h8A, 8'h8F};
    logic [7:0] wv [5] = '{8'hF5, 8'h0F, 8'h20, 8'h08, 8'hFF};
    int errors = 0, comparisons = 0;
    bbsc_top DUT (.clk_in, .arst_n_in, .load_clock_in, .blank_n_in, .border_n_in, .line_sync_in,
        .frame_or_combined_sync_in, .pixel_in, .border_colour_in, .cursor_show_in, .cursor_colour_in,
        .bits_per_pixel_in, .contig_format_in, .palette_partition_in, .low_bit_fill_sel_in, .reg_index_in,
        .reg_wdata_in, .reg_write_in, .reg_rdata_out, .dac_data_out, .dac_sync_on_green_out,
        .palette_index_hi_out, .fill_bits_out, .line_sync_out, .line_sync_oe_out, .frame_sync_out,
        .frame_sync_oe_out, .frame_end_out, .cursor_area_out, .signature_en_out, .data_stall_out);
    bbsc_ctrl_model u_ctrl (.run_in(run), .vblank_in(vblank), .load_clock_out(load_clock_in),
        .blank_n_out(blank_n_in), .border_n_out(border_n_in), .pixel_out(pixel_in));
    // 125 MHz system clock
    initial begin
        forever #4 clk_in = ~clk_in;
    end
    task automatic close_out();
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_rng(input int got, input int lo, input int hi);
        comparisons++;
        if (got < lo || got > hi) begin
            errors++;
            $display("ERROR t=%0t count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk_in);
        #1;
    endtask
    task automatic wreg(input logic [7:0] i, input logic [7:0] d);
        reg_index_in = i;
        reg_wdata_in = d;
        reg_write_in = 1'b1;
        tick(1);
        reg_write_in = 1'b0;
        tick(1);
    endtask
    // {drive enable, level} expected for a drive field
    function automatic logic [1:0] sexp(input logic [1:0] m, input logic v);
        return m == 2'h0 ? {1'b1, v} : m == 2'h1 ? 2'b10 : m == 2'h2 ? 2'b11 : 2'b00;
    endfunction
    // cycles until line sync (g=0) or green sync (g=1) changes
    task automatic wait_chg(input logic g, output int c);
        logic v;
        v = g ? dac_sync_on_green_out : line_sync_out;
        c = 0;
        while ((g ? dac_sync_on_green_out : line_sync_out) === v && c < 1000) begin
            tick(1);
            c++;
        end
        if (c >= 1000) begin
            errors++;
            $display("ERROR t=%0t sync never changed", $time);
            close_out();
        end
    endtask
    task automatic t_regs();
        for (int i = 0; i < 5; i++) begin
            reg_index_in = 8'(i + 3);
            tick(2);
            cmp(reg_rdata_out, 8'h00);
        end
        for (int i = 0; i < 5; i++) wreg(8'(i + 3), wv[i]);
        for (int i = 0; i < 5; i++) begin
            reg_index_in = 8'(i + 3);
            tick(2);
            cmp(reg_rdata_out, i == 4 ? 8'h00 : wv[i]);
        end
        for (int i = 3; i < 7; i++) wreg(8'(i), 8'h00);
        $display("t_regs done");
    endtask
    task automatic t_frame();
        tick(2030 * 20);
        cmp(frame_end_out, 1'b0);
        tick(40 * 20);
        cmp({frame_end_out, signature_en_out, cursor_area_out}, 3'b100);
        cmp(dac_data_out, 24'h000000);
        vblank = 1'b0;
        tick(70 * 20);
        cmp(frame_end_out, 1'b0);
        $display("t_frame done");
    endtask
    task automatic t_line(input logic show);
        int nz, nb, nd, na, ns;
        cursor_show_in = show;
        {nz, nb, nd, na, ns} = '0;
        tick(200);
        repeat (1280) begin
            tick(1);
            nz += int'(dac_data_out === 24'h000000);
            nb += int'(dac_data_out === border_colour_in);
            nd += int'(show ? dac_data_out === cursor_colour_in
                : (dac_data_out[7:0] !== 8'h00 && dac_data_out === {3{dac_data_out[7:0]}}));
            na += int'(cursor_area_out === 1'b1);
            ns += int'(signature_en_out === 1'b1);
        end
        cmp_rng(nz, 140, 180);
        cmp_rng(nb, 140, 180);
        cmp_rng(nd, 940, 980);
        cmp_rng(na, 940, 980);
        cmp_rng(ns, 1100, 1140);
        cmp(data_stall_out, 1'b0);
        bits_per_pixel_in = 2'h2;
        tick(200);
        cmp(fill_bits_out, 8'h00);
        low_bit_fill_sel_in = 1'b1;
        tick(2);
        cmp(fill_bits_out, 8'hFF);
        low_bit_fill_sel_in = 1'b0;
        contig_format_in = 1'b1;
        tick(2);
        cmp(palette_index_hi_out[7:4], palette_partition_in);
        contig_format_in = 1'b0;
        bits_per_pixel_in = 2'h0;
        tick(200);
        cmp(palette_index_hi_out[7:4], palette_partition_in);
        bits_per_pixel_in = 2'h1;
        $display("t_line done");
    endtask
    task automatic t_sync();
        for (int i = 0; i < 12; i++) begin
            wreg(8'h03, scv[i / 2]);
            line_sync_in = i[0];
            frame_or_combined_sync_in = ~i[0];
            tick(6);
            cmp({line_sync_oe_out, line_sync_oe_out & line_sync_out},
                sexp(scv[i / 2][1:0], i[0] ^ scv[i / 2][4]));
            cmp({frame_sync_oe_out, frame_sync_oe_out & frame_sync_out},
                sexp(scv[i / 2][3:2], ~i[0] ^ scv[i / 2][5]));
        end
        $display("t_sync done");
    endtask
    task automatic t_delay(input logic g, input logic [3:0] p, input int lo);
        int c;
        wreg(8'h04, {4'h0, p});
        tick(600);
        if (g) frame_or_combined_sync_in = ~frame_or_combined_sync_in;
        else line_sync_in = ~line_sync_in;
        wait_chg(g, c);
        cmp_rng(c, lo, lo + 70);
        $display("t_delay done");
    endtask
    initial begin
        int c;
        logic v;
        repeat (6) @(posedge clk_in);
        #1;
        arst_n_in = 1'b1;
        run = 1'b1;
        tick(3);
        t_regs();
        t_frame();
        t_line(1'b1);
        t_line(1'b0);
        t_sync();
        wreg(8'h03, 8'h00);
        t_delay(1'b0, 4'h0, 60);
        t_delay(1'b0, 4'hF, 360);
        wreg(8'h05, 8'h20);
        tick(10);
        v = line_sync_out;
        line_sync_in = ~line_sync_in;
        tick(600);
        cmp(line_sync_out, v);
        wreg(8'h05, 8'h00);
        wreg(8'h06, 8'h08);
        tick(600);
        line_sync_in = ~line_sync_in;
        wait_chg(1'b0, c);
        cmp_rng(c, 0, 4);
        t_delay(1'b1, 4'hF, 360);
        v = dac_sync_on_green_out;
        wreg(8'h03, 8'h40);
        tick(600);
        cmp(dac_sync_on_green_out, !v);
        close_out();
    end
endmodule
